//--- logic/scp_clock_power.sv
// Clock source selection, machine cycle strobe and power management control.
//
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/100ps
`include "scp_cfg.svh"
module scp_clock_power #(
	parameter int READY_COUNT = `SCP_READY_COUNT,
	parameter int RING_COUNT  = `SCP_RING_COUNT
) (
	input  wire logic                   core_clk,
	input  wire logic                   rst,
	input  wire logic                   clk_en,
	input  wire logic [7:0]             avs_address,
	input  wire logic                   avs_read,
	input  wire logic                   avs_write,
	input  wire scp_pkg::scp_byte_t     avs_writedata,
	output logic      [7:0]             avs_readdata,
	output logic                        avs_waitrequest,
	input  wire logic                   osc_tick,
	input  wire logic                   osc_stopped_slow,
	input  wire logic                   stop_mode,
	input  wire logic                   ring_exit,
	input  wire logic                   power_fail_reset,
	input  wire logic                   int_ack,
	input  wire logic                   powerfail_level_in_service,
	input  wire logic                   high_level_in_service,
	input  wire logic                   low_level_in_service,
	input  wire logic [1:0]             serial_start_bit,
	input  wire logic [1:0]             serial_tx_buffer_write,
	input  wire logic [1:0]             serial_enabled,
	input  wire logic [1:0]             serial_active,
	output logic      [1:0]             clk_src_sel,
	output logic                        multiplier_on,
	output logic                        multiplier_x4,
	output logic                        sys_tick,
	output logic                        mc_tick,
	output logic                        periph_tick,
	output logic                        cpu_reset_hold
);
	import scp_pkg::*;

	// Lock and handover counters are sized for the default count of 65536.
	// A count above 131072 needs CW raised as well, or the compare value is truncated.
	localparam int CW = 17;
	localparam logic [CW-1:0] READY_LAST = CW'(READY_COUNT - 1);
	localparam logic [CW-1:0] RING_LAST  = CW'(RING_COUNT - 1);
	localparam logic [7:0] SLOW_LAST = 8'(`SCP_DIV_SLOW - 1);
	localparam logic [9:0] PMM_LAST  = 10'(`SCP_PMM_DIV - 1);
	localparam logic [1:0] MC_LAST   = 2'(`SCP_MC_DIV - 1);

	////////////////////////////////////////////////////////////////////////
	// All state of the block lives in one packed record.

	typedef struct packed {
		logic [1:0]    cd;
		logic [1:0]    cd_pend;
		logic          pend;
		logic          switchback_enable;
		logic          multiplier_enable;
		logic          fact;
		logic          ready;
		logic          ring;
		logic          osc_fail_detect_enable;
		logic          osc_fail_flag;
		scp_ta_e       ta;
		logic [1:0]    ta_cnt;
		logic [CW-1:0] rdy_cnt;
		logic [CW-1:0] ring_cnt;
		logic [7:0]    slow_cnt;
		logic [9:0]    pmm_cnt;
		logic [1:0]    mc_cnt;
		logic [7:0]    rdata;
		logic          wait_n;
		logic [1:0]    src;
		logic          mult_on;
		logic          x4;
		logic          sys;
		logic          mc;
		logic          per;
		logic          hold;
	} scp_state_s;

	scp_state_s s_q;
	scp_state_s s_d;

	logic       acc;
	logic       wr;
	logic       rd;
	logic       pmr_wr;
	logic       power_control_register_wr;
	logic       ta_wr;
	logic       ta_open;
	logic       sys_now;
	logic       per_now;
	logic       sb_evt;
	logic [1:0] sp_wake;
	logic [1:0] cd_req;
	logic       cd_ok;
	logic       mult_ok;
	logic       serial_idle;
	logic [7:0] status;

	////////////////////////////////////////////////////////////////////////
	// Serial wake-up requests, one per port.

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_sp
			assign sp_wake[gi] = serial_enabled[gi] &
				(serial_start_bit[gi] | serial_tx_buffer_write[gi]);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Bus decode, divide-code legality and clock strobes.

	always_comb begin
		// A request is taken while waitrequest stands high; a write lands
		// at the following edge, the one where the master sees it low.
		acc = (avs_read | avs_write) & s_q.wait_n;
		rd = avs_read & s_q.wait_n;
		wr = avs_write & ~s_q.wait_n;
		pmr_wr = wr & (avs_address == `SCP_OFF_PMR);
		power_control_register_wr = wr & (avs_address == `SCP_OFF_POWER_CONTROL_REGISTER);
		ta_wr = wr & (avs_address == `SCP_OFF_TA);
		ta_open = (s_q.ta == SCP_TA_OPEN);
		cd_req = avs_writedata[`SCP_PMR_CD_HI:`SCP_PMR_CD_LO];
		serial_idle = (serial_active == 2'b00);
		status = {powerfail_level_in_service,
			high_level_in_service,
			low_level_in_service,
			3'b000,
			serial_active};
		mult_ok = s_q.multiplier_enable & s_q.ready & ~s_q.ring;
		cd_ok = 1'b0;
		if (cd_req == s_q.cd) begin
			cd_ok = 1'b0;
		end else if (cd_req == `SCP_CD_RSVD) begin
			cd_ok = 1'b0;
		end else if (s_q.cd == `SCP_CD_DIV4) begin
			cd_ok = (cd_req == `SCP_CD_PMM) | mult_ok;
		end else begin
			cd_ok = (cd_req == `SCP_CD_DIV4);
		end
		// The multiplied clock itself is made by the clock generator; this
		// block only tells it, through multiplier_on and multiplier_x4,
		// which factor to run, so sys_tick follows the oscillator base.
		// system clock strobe per source
		unique case (s_q.src)
			`SCP_CD_MULT: sys_now = osc_tick;
			`SCP_CD_PMM:  sys_now = osc_tick & (s_q.slow_cnt == SLOW_LAST);
			default:      sys_now = osc_tick;
		endcase
		per_now = sys_now;
		if (s_q.src == `SCP_CD_PMM) begin
			per_now = osc_tick & (s_q.pmm_cnt == PMM_LAST);
		end
		// switchback triggers
		// The processor raises int_ack only for enabled, unblocked sources.
		sb_evt = int_ack | (|sp_wake);
	end

	////////////////////////////////////////////////////////////////////////
	// Next-state logic.

	always_comb begin
		s_d = s_q;
		s_d.wait_n = ~acc;
		s_d.sys = 1'b0;
		s_d.mc = 1'b0;
		s_d.per = 1'b0;
		if (rd) begin
			unique case (avs_address)
				`SCP_OFF_PMR: s_d.rdata = {s_q.cd,
					s_q.switchback_enable,
					s_q.multiplier_enable,
					s_q.fact,
					3'b000};
				`SCP_OFF_POWER_CONTROL_REGISTER: s_d.rdata = {2'b00,
					s_q.osc_fail_flag,
					s_q.osc_fail_detect_enable,
					4'h0};
				`SCP_OFF_EXTERNAL_INT_FLAG_REGISTER: s_d.rdata = {3'b000,
					s_q.ready,
					1'b0,
					s_q.ring,
					2'b00};
				`SCP_OFF_STATUS: s_d.rdata = status;
				default: s_d.rdata = 8'h00;
			endcase
		end
		////////////////////////////////////////////////////////////////
		// The window counts enabled edges, so a frozen clock does not
		// shorten the time software has for its protected write.
		// timed-access key sequence
		unique case (s_q.ta)
			SCP_TA_IDLE: begin
				if (ta_wr && avs_writedata == `SCP_TA_KEY1) begin
					s_d.ta = SCP_TA_KEY;
				end
			end
			SCP_TA_KEY: begin
				if (ta_wr && avs_writedata == `SCP_TA_KEY2) begin
					s_d.ta = SCP_TA_OPEN;
					s_d.ta_cnt = 2'(`SCP_TA_WINDOW - 1);
				end else if (ta_wr && avs_writedata != `SCP_TA_KEY1) begin
					s_d.ta = SCP_TA_IDLE;
				end
			end
			SCP_TA_OPEN: begin
				if (ta_wr) begin
					s_d.ta = (avs_writedata == `SCP_TA_KEY1) ?
						SCP_TA_KEY : SCP_TA_IDLE;
				end else if (s_q.ta_cnt == 2'd0) begin
					s_d.ta = SCP_TA_IDLE;
				end else begin
					s_d.ta_cnt = s_q.ta_cnt - 2'd1;
				end
			end
			default: begin
				s_d.ta = SCP_TA_IDLE;
			end
		endcase
		////////////////////////////////////////////////////////////////
		// Register writes.
		if (pmr_wr) begin
			s_d.switchback_enable = avs_writedata[`SCP_PMR_SWB];
			// enable and factor only in divide-by-four
			if (s_q.cd == `SCP_CD_DIV4) begin
				s_d.multiplier_enable = avs_writedata[`SCP_PMR_CTM];
				if (~s_q.multiplier_enable) begin
					s_d.fact = avs_writedata[`SCP_PMR_FACT];
				end
				if (~avs_writedata[`SCP_PMR_CTM]) begin
					s_d.ready = 1'b0;
					s_d.rdy_cnt = '0;
				end
			end
			if (cd_ok && serial_idle) begin
				s_d.cd = cd_req;
				s_d.cd_pend = cd_req;
				s_d.pend = 1'b1;
			end
		end
		if (power_control_register_wr) begin
			if (ta_open) begin
				s_d.osc_fail_detect_enable = avs_writedata[`SCP_POWER_CONTROL_REGISTER_EN];
				s_d.ta = SCP_TA_IDLE;
			end
			if (~avs_writedata[`SCP_POWER_CONTROL_REGISTER_FLAG]) begin
				s_d.osc_fail_flag = 1'b0;
			end
		end
		////////////////////////////////////////////////////////////////
		// Switchback is applied after the write so that it wins when both
		// fall in one cycle; otherwise a late write could strand the core
		// in slow mode just as a serial character starts.
		// hardware return to divide-by-four wins over writes
		if (s_q.switchback_enable && s_q.cd == `SCP_CD_PMM && sb_evt) begin
			s_d.cd = `SCP_CD_DIV4;
			s_d.cd_pend = `SCP_CD_DIV4;
			s_d.pend = 1'b1;
		end
		////////////////////////////////////////////////////////////////
		// Counters on the oscillator time base.
		if (osc_tick) begin
			if (s_q.multiplier_enable && !s_q.ready) begin
				s_d.rdy_cnt = s_q.rdy_cnt + 1'b1;
				if (s_q.rdy_cnt == READY_LAST) begin
					s_d.ready = 1'b1;
				end
			end
			if (s_q.ring) begin
				s_d.ring_cnt = s_q.ring_cnt + 1'b1;
				if (s_q.ring_cnt == RING_LAST) begin
					s_d.ring = 1'b0;
				end
			end
			s_d.slow_cnt = s_q.slow_cnt + 1'b1;
			s_d.pmm_cnt = s_q.pmm_cnt + 1'b1;
		end
		if (ring_exit) begin
			s_d.ring = 1'b1;
			s_d.ring_cnt = '0;
		end
		if (sys_now) begin
			s_d.sys = 1'b1;
			s_d.mc_cnt = s_q.mc_cnt + 1'b1;
			if (s_q.mc_cnt == MC_LAST) begin
				s_d.mc = 1'b1;
				// apply at next machine cycle boundary
				if (s_q.pend) begin
					s_d.pend = 1'b0;
					s_d.src = s_q.cd_pend;
					s_d.mult_on = (s_q.cd_pend == `SCP_CD_MULT);
					s_d.x4 = s_q.fact;
				end
			end
		end
		s_d.per = per_now;
		////////////////////////////////////////////////////////////////
		// The fail flag is set after the software clear so that a failure
		// in the same cycle is never lost; a power-fail reset still wins.
		// fail detect and reset hold
		if (s_q.osc_fail_detect_enable && osc_stopped_slow && !stop_mode) begin
			s_d.osc_fail_flag = 1'b1;
		end
		if (power_fail_reset) begin
			s_d.osc_fail_flag = 1'b0;
		end
		s_d.hold = s_q.osc_fail_detect_enable & osc_stopped_slow & ~stop_mode;
	end

	////////////////////////////////////////////////////////////////////////
	// State register; clk_en low freezes every field.

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s_q <= '{cd: `SCP_CD_RESET,
				cd_pend: `SCP_CD_RESET,
				src: `SCP_CD_RESET,
				ta: SCP_TA_IDLE,
				wait_n: 1'b1,
				default: '0};
		end else if (clk_en) begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Every output is a field of the state register.

	assign avs_readdata    = s_q.rdata;
	assign avs_waitrequest = s_q.wait_n;
	assign clk_src_sel     = s_q.src;
	assign multiplier_on   = s_q.mult_on;
	assign multiplier_x4   = s_q.x4;
	assign sys_tick        = s_q.sys;
	assign mc_tick         = s_q.mc;
	assign periph_tick     = s_q.per;
	assign cpu_reset_hold  = s_q.hold;
endmodule

//--- logic/scp_cfg.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef SCP_CFG_SVH
`define SCP_CFG_SVH
`define SCP_ADDR_W          8
`define SCP_OFF_PMR         8'h00
`define SCP_OFF_POWER_CONTROL_REGISTER        8'h01
`define SCP_OFF_EXTERNAL_INT_FLAG_REGISTER        8'h02
`define SCP_OFF_TA          8'h03
`define SCP_OFF_STATUS      8'hc5
`define SCP_PMR_CD_HI       7
`define SCP_PMR_CD_LO       6
`define SCP_PMR_SWB         5
`define SCP_PMR_CTM         4
`define SCP_PMR_FACT        3
`define SCP_POWER_CONTROL_REGISTER_FLAG       5
`define SCP_POWER_CONTROL_REGISTER_EN         4
`define SCP_EXTERNAL_INT_FLAG_REGISTER_READY      4
`define SCP_EXTERNAL_INT_FLAG_REGISTER_RING       2
`define SCP_ST_PF           7
`define SCP_ST_HI           6
`define SCP_ST_LO           5
`define SCP_ST_SP1          1
`define SCP_ST_SP0          0
`define SCP_CD_MULT         2'b00
`define SCP_CD_RSVD         2'b01
`define SCP_CD_DIV4         2'b10
`define SCP_CD_PMM          2'b11
`define SCP_CD_RESET        2'b10
`define SCP_TA_KEY1         8'haa
`define SCP_TA_KEY2         8'h55
`define SCP_TA_WINDOW       3
`define SCP_READY_COUNT     65536
`define SCP_RING_COUNT      65536
`define SCP_DIV_SLOW        256
`define SCP_MC_DIV          4
`define SCP_PMM_DIV         1024
`endif

//--- logic/scp_pkg.sv
// Types shared by the clock and power control block.
package scp_pkg;
	typedef enum logic [3:0] {
		SCP_TA_IDLE  = 4'b0001,
		SCP_TA_KEY   = 4'b0010,
		SCP_TA_OPEN  = 4'b0100,
		SCP_TA_SPARE = 4'b1000
	} scp_ta_e;
	typedef logic [7:0] scp_byte_t;
endpackage

//--- tb/scp_osc_model.sv
// Behavioural crystal feeding the block's oscillator time base.
`timescale 1ns/100ps
module scp_osc_model (
	input  wire logic core_clk,
	input  wire logic halt,
	input  wire logic slow,
	output logic      osc_tick,
	output logic      osc_stopped_slow
);
	logic [1:0] cnt = 2'd0;
	initial osc_tick = 1'b0;
	always @(posedge core_clk) begin
		cnt <= (halt || cnt == (slow ? 2'd3 : 2'd1)) ? 2'd0 : cnt + 2'd1;
		osc_tick <= !halt && cnt == 2'd0;
	end
	assign osc_stopped_slow = halt;
endmodule

//--- tb/scp_clock_power_monitor.sv
// Checker on the ports of the clock and power control block.
`timescale 1ns/100ps
module scp_monitor (
	input wire logic       core_clk,
	input wire logic       rst,
	input wire logic       clk_en,
	input wire logic       avs_read,
	input wire logic       avs_write,
	input wire logic       avs_waitrequest,
	input wire logic [7:0] avs_readdata,
	input wire logic       osc_stopped_slow,
	input wire logic       stop_mode,
	input wire logic [1:0] clk_src_sel,
	input wire logic       multiplier_x4,
	input wire logic       sys_tick,
	input wire logic       mc_tick,
	input wire logic       cpu_reset_hold
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	AST_WAIT_ONE:
	assert property (!avs_waitrequest && clk_en |=> avs_waitrequest)
		else $error("waitrequest low too long");
	AST_ACCEPT:
	assert property ((avs_read || avs_write) && avs_waitrequest && clk_en
		|=> !avs_waitrequest) else $error("request not accepted");
	AST_RD_HOLD:
	assert property (avs_waitrequest |-> $stable(avs_readdata))
		else $error("read data moved while idle");
	AST_RSVD:
	assert property (clk_src_sel != 2'b01) else $error("reserved code used");
	AST_VIA_DIV4:
	assert property ($changed(clk_src_sel) |-> clk_src_sel == 2'b10
		|| $past(clk_src_sel) == 2'b10) else $error("bad divide change");
	AST_X4_KEPT:
	assert property ($past(clk_src_sel) == 2'b00 && clk_src_sel == 2'b00
		|-> $stable(multiplier_x4)) else $error("factor moved in use");
	AST_MC:
	assert property (mc_tick |-> sys_tick) else $error("stray machine tick");
	AST_HOLD:
	assert property (cpu_reset_hold && $past(clk_en) |-> $past(osc_stopped_slow)
		&& !$past(stop_mode)) else $error("reset hold without cause");
endmodule
bind scp_clock_power scp_monitor mon_u (.core_clk, .rst, .clk_en,
	.avs_read, .avs_write, .avs_waitrequest, .avs_readdata,
	.osc_stopped_slow, .stop_mode, .clk_src_sel, .multiplier_x4,
	.sys_tick, .mc_tick, .cpu_reset_hold);

//--- tb/tb.sv
// Self-checking bench for the clock and power control block.
`timescale 1ns/100ps
module tb;
	import scp_pkg::*;
	logic core_clk = 0, rst = 1, clk_en = 1, avs_read = 0, avs_write = 0;
	logic stop_mode = 0, ring_exit = 0, power_fail_reset = 0, int_ack = 0;
	logic pf = 0, hi = 0, lo = 0, halt = 0, slow = 0;
	logic [1:0] sp_start = 0, sp_tx = 0, sp_en = 3, sp_act = 0, clk_src_sel;
	logic [7:0] avs_address = 0, q, v, avs_readdata;
	scp_byte_t avs_writedata = 0;
	logic avs_waitrequest, osc_tick, osc_stopped_slow, multiplier_on;
	logic multiplier_x4, sys_tick, mc_tick, periph_tick, cpu_reset_hold;
	int errors = 0, n_compared = 0, cyc = 0, seed = 80069, n, k;
	scp_clock_power #(.READY_COUNT(8), .RING_COUNT(8)) dut_u (
		.core_clk, .rst, .clk_en, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_readdata, .avs_waitrequest, .osc_tick,
		.osc_stopped_slow, .stop_mode, .ring_exit, .power_fail_reset,
		.int_ack, .powerfail_level_in_service(pf),
		.high_level_in_service(hi), .low_level_in_service(lo),
		.serial_start_bit(sp_start), .serial_tx_buffer_write(sp_tx),
		.serial_enabled(sp_en), .serial_active(sp_act), .clk_src_sel,
		.multiplier_on, .multiplier_x4, .sys_tick, .mc_tick, .periph_tick,
		.cpu_reset_hold);
	scp_osc_model osc_u (.core_clk, .halt, .slow, .osc_tick, .osc_stopped_slow);
	always #2 core_clk = ~core_clk;
	task automatic give_verdict;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	always @(posedge core_clk) if (++cyc == 60000) begin
		errors++;
		give_verdict;
	end
	task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask
	// Request held until waitrequest is seen low at a rising edge.
	task automatic bus(logic w, logic [7:0] a, logic [7:0] d);
		int i;
		i = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		do begin
			@(posedge core_clk);
			i++;
		end while (avs_waitrequest !== 1'b0 && i < 50);
		q = avs_readdata;
		avs_write <= 0;
		avs_read <= 0;
		@(posedge core_clk);
		if (i >= 50) errors++;
	endtask
	task automatic pm(logic [7:0] e);
		bus(0, 8'h00, 0);
		chk("pmr_code", e, {6'd0, q[7:6]});
	endtask
	task automatic wsel(logic [1:0] e);
		n = 0;
		while (clk_src_sel !== e && n < 5000) begin
			@(posedge core_clk);
			n++;
		end
		chk("clk_src_sel", {6'd0, e}, {6'd0, clk_src_sel});
	endtask
	task automatic pulse(int s);
		int_ack <= s == 0;
		sp_start <= {1'b0, s == 1};
		sp_tx <= {s == 2, 1'b0};
		@(posedge core_clk);
		{int_ack, sp_start, sp_tx} <= 0;
	endtask
	initial begin
		repeat (4) @(posedge core_clk);
		rst <= 0;
		@(posedge core_clk);
		wsel(2);
		repeat (4) begin
			v = $random(seed);
			{pf, hi, lo, sp_act, slow} <= v[5:0];
			@(posedge core_clk);
			bus(0, 8'hc5, 0);
			chk("status", {v[5:3], 3'd0, v[2:1]}, q);
		end
		sp_act <= 2'b01;
		bus(1, 0, 8'hc0);
		pm(2);
		{pf, hi, lo, sp_act} <= 0;
		bus(0, 8'h10, 0);
		chk("unmapped", 0, q);
		bus(1, 0, 8'h40);
		pm(2);
		for (k = 0; k < 4; k++) begin
			sp_en <= (k == 3) ? 2'b00 : 2'b11;
			bus(0, 8'hc5, 0);
			chk("levels_idle", 0, q & 8'he0);
			bus(1, 0, 8'he0);
			wsel(3);
			if (k == 0) bus(1, 0, 8'h20);
			if (k == 0) pm(3);
			pulse(k == 3 ? 1 : k);
			pm(k == 3 ? 3 : 2);
			if (k == 3) bus(1, 0, 8'h80);
			wsel(2);
		end
		bus(1, 0, 8'h88);
		bus(1, 0, 8'h98);
		bus(1, 0, 8'h18);
		pm(2);
		bus(0, 8'h02, 0);
		chk("ready_early", 0, q[4]);
		n = 0;
		while (q[4] !== 1'b1 && n < 100) begin
			bus(0, 8'h02, 0);
			n++;
		end
		chk("ready", 1, q[4]);
		bus(1, 0, 8'h18);
		pm(0);
		wsel(0);
		chk("x4", 1, multiplier_x4);
		chk("mult_on", 1, multiplier_on);
		bus(1, 0, 8'hd8);
		pm(0);
		bus(1, 0, 8'h98);
		pm(2);
		bus(1, 1, 8'h10);
		bus(0, 1, 0);
		chk("fail_en_untimed", 0, q[4]);
		bus(1, 3, 8'haa);
		bus(1, 3, 8'h55);
		bus(1, 1, 8'h10);
		bus(0, 1, 0);
		chk("fail_en", 1, q[4]);
		{stop_mode, halt} <= 2'b11;
		repeat (8) @(posedge core_clk);
		chk("hold_stop", 0, cpu_reset_hold);
		stop_mode <= 0;
		repeat (8) @(posedge core_clk);
		chk("hold", 1, cpu_reset_hold);
		halt <= 0;
		repeat (8) @(posedge core_clk);
		bus(0, 1, 0);
		chk("fail_flag", 1, q[5]);
		bus(1, 1, 8'h00);
		bus(0, 1, 0);
		chk("fail_clear", 8'h10, q & 8'h30);
		give_verdict;
	end
endmodule
